/* File: hdl/irq_mask_pkg.sv */
// How it works
// - A source whose enable bit is clear never reaches the interrupt output.
// - Flags stay visible and unmasked at 0x044; the enable gates the interrupt and the pending view at 0x040.
// - Enable word sits at offset 0x018 and resets to all zeros.
// - Bit 31 enables the wakeup interrupt, in both roles.
// - Bit 30 enables the session interrupt, in both roles.
// - Bit 29 enables the disconnect interrupt, device role only.
// - Bit 28 enables the ID pin status change interrupt, in both roles.
// - Bit 26 enables the periodic transmit FIFO empty interrupt, host role only.
// - Bit 25 enables the host channels interrupt, host role only.
// - Bit 24 enables the host port interrupt, host role only.
// - Host role: bit 21 enables the periodic transfer incomplete interrupt.
// - Device role: bit 21 enables the isochronous OUT incomplete interrupt.
// - Bit 20 enables the isochronous IN incomplete interrupt, device role only.
// - Bit 19 enables the OUT endpoints interrupt, device role only.
// - Bit 18 enables the IN endpoints interrupt, device role only.
// - Bit 15 enables the end of periodic frame interrupt, device role only.
// - Bit 14 enables the isochronous OUT packet dropped interrupt, device role only.
// - Bit 13 enables the enumeration done interrupt, device role only.
// - Bit 12 enables the bus reset interrupt, device role only.
// - Bit 11 enables the bus suspend interrupt, device role only.
// - Bit 10 enables the early suspend interrupt.
// - Writing a new value to a control of the wrong role has no effect and raises mode fault.
package irq_mask_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SYNC_STAGES = 2;

  // Register offsets
  localparam logic [11:0] ENABLE_OFFSET     = 12'h018;
  localparam logic [11:0] PENDING_OFFSET    = 12'h040;
  localparam logic [11:0] FLAGS_VIEW_OFFSET = 12'h044;

  // Reset values
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] READ_IDLE    = 32'h00000000;

  // Field positions
  localparam int unsigned WAKEUP_BIT        = 31;
  localparam int unsigned SESSION_BIT       = 30;
  localparam int unsigned DISCONNECT_BIT    = 29;
  localparam int unsigned ID_PIN_BIT        = 28;
  localparam int unsigned PERIODIC_TXFE_BIT = 26;
  localparam int unsigned HOST_CHANNELS_BIT = 25;
  localparam int unsigned HOST_PORT_BIT     = 24;
  localparam int unsigned INCOMPLETE_BIT    = 21;
  localparam int unsigned ISO_IN_BIT        = 20;
  localparam int unsigned OUT_EP_BIT        = 19;
  localparam int unsigned IN_EP_BIT         = 18;
  localparam int unsigned END_FRAME_BIT     = 15;
  localparam int unsigned ISO_DROP_BIT      = 14;
  localparam int unsigned ENUM_DONE_BIT     = 13;
  localparam int unsigned BUS_RESET_BIT     = 12;
  localparam int unsigned SUSPEND_BIT       = 11;
  localparam int unsigned EARLY_SUSPEND_BIT = 10;

  // Role groups of the enable word
  localparam logic [31:0] BOTH_ROLE_MASK   = 32'hD0200000;
  localparam logic [31:0] HOST_ONLY_MASK   = 32'h07000000;
  localparam logic [31:0] DEVICE_ONLY_MASK = 32'h201CFC00;
  localparam logic [31:0] WRITABLE_MASK    = 32'hF73CFC00;

  // Bits that the current role may not touch
  function automatic logic [31:0] wrong_role_mask(input logic host_mode);
    wrong_role_mask = host_mode ? DEVICE_ONLY_MASK : HOST_ONLY_MASK;
  endfunction

endpackage

/* File: hdl/reset_sync.sv */
module reset_sync
  import irq_mask_pkg::*;
(
  // Clock and raw reset
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  // Released reset
  output logic      nrst_sync_out
);

  logic [SYNC_STAGES-1:0] nrst_chain_reg;

  // Assert at once, release after two edges
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nrst_chain_reg <= '0;
    end else begin
      nrst_chain_reg <= {nrst_chain_reg[SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign nrst_sync_out = nrst_chain_reg[SYNC_STAGES-1];

endmodule

/* File: hdl/irq_gate.sv */
module irq_gate #(
  parameter int unsigned WIDTH = 32
) (
  // Sources and enables
  input  wire logic [WIDTH-1:0] flags_in,
  input  wire logic [WIDTH-1:0] enables_in,
  // Gated result
  output logic      [WIDTH-1:0] pending_out,
  output logic                  any_out
);

  // Per-source gate
  for (genvar i = 0; i < WIDTH; i++) begin : g_gate
    assign pending_out[i] = flags_in[i] & enables_in[i];
  end

  assign any_out = |pending_out;

endmodule

/* File: hdl/usb_irq_enable_mask.sv */
// Chosen here: the strobed register port.
module usb_irq_enable_mask
  import irq_mask_pkg::*;
#(
  parameter bit HOST_PORT_WRITABLE = 1'b1
) (
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  // Controller side
  input  wire logic [DATA_W-1:0] global_interrupt_flags_in,
  input  wire logic              host_mode_in,
  output logic      [DATA_W-1:0] global_interrupt_enable_out,
  output logic                   mode_fault_flag_out,
  // Processor interrupt
  output logic                   irq_out
);

  logic              nrst_sync;
  logic [DATA_W-1:0] enable_reg;
  logic [DATA_W-1:0] enable_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              irq_reg;
  logic              irq_next;
  logic              fault_reg;
  logic              fault_next;
  logic [DATA_W-1:0] pending;
  logic              any_pending;

  // One-hot word for a field
  function automatic logic [DATA_W-1:0] only_bit(input int unsigned pos);
    only_bit      = '0;
    only_bit[pos] = 1'b1;
  endfunction

  // Reset release
  reset_sync u_reset_sync (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .nrst_sync_out (nrst_sync)
  );

  // Source gating
  irq_gate #(
    .WIDTH (DATA_W)
  ) u_irq_gate (
    .flags_in    (global_interrupt_flags_in),
    .enables_in  (enable_reg),
    .pending_out (pending),
    .any_out     (any_pending)
  );

  // Address decode
  wire enable_sel  = (addr_in == ENABLE_OFFSET);
  wire pending_sel = (addr_in == PENDING_OFFSET);
  wire flags_sel   = (addr_in == FLAGS_VIEW_OFFSET);
  wire enable_hit  = wr_in && enable_sel;

  // Writable field set
  wire [DATA_W-1:0] host_port_keep = HOST_PORT_WRITABLE ? 32'h00000000 : (32'h00000001 << HOST_PORT_BIT);
  wire [DATA_W-1:0] field_mask     = WRITABLE_MASK & ~host_port_keep;

  // Role guard
  wire [DATA_W-1:0] blocked    = wrong_role_mask(host_mode_in) | ~field_mask;
  wire [DATA_W-1:0] write_bits = wdata_in & field_mask;
  wire [DATA_W-1:0] role_bits  = wrong_role_mask(host_mode_in);
  wire              role_touch = |((write_bits ^ enable_reg) & role_bits);

  // Enable word update
  wire [DATA_W-1:0] merged_word = (write_bits & ~blocked) | (enable_reg & blocked);

  assign enable_next = enable_hit ? merged_word : enable_reg;
  assign fault_next  = enable_hit && role_touch;

  // Enable fields by name
  wire wakeup_irq_en                   = enable_reg[WAKEUP_BIT];
  wire session_irq_en                  = enable_reg[SESSION_BIT];
  wire disconnect_irq_en               = enable_reg[DISCONNECT_BIT];
  wire id_pin_change_irq_en            = enable_reg[ID_PIN_BIT];
  wire periodic_tx_fifo_empty_irq_en   = enable_reg[PERIODIC_TXFE_BIT];
  wire host_channels_irq_en            = enable_reg[HOST_CHANNELS_BIT];
  wire host_port_irq_en                = enable_reg[HOST_PORT_BIT];
  wire periodic_xfer_incomplete_irq_en = enable_reg[INCOMPLETE_BIT];
  wire iso_out_incomplete_irq_en       = enable_reg[INCOMPLETE_BIT];
  wire iso_in_incomplete_irq_en        = enable_reg[ISO_IN_BIT];
  wire out_endpoints_irq_en            = enable_reg[OUT_EP_BIT];
  wire in_endpoints_irq_en             = enable_reg[IN_EP_BIT];
  wire end_periodic_frame_irq_en       = enable_reg[END_FRAME_BIT];
  wire iso_out_drop_irq_en             = enable_reg[ISO_DROP_BIT];
  wire enum_done_irq_en                = enable_reg[ENUM_DONE_BIT];
  wire bus_reset_irq_en                = enable_reg[BUS_RESET_BIT];
  wire suspend_irq_en                  = enable_reg[SUSPEND_BIT];
  wire early_suspend_irq_en            = enable_reg[EARLY_SUSPEND_BIT];

  // Read selection
  wire [DATA_W-1:0] read_word = enable_sel  ? enable_reg :
                                pending_sel ? pending :
                                flags_sel   ? global_interrupt_flags_in :
                                READ_IDLE;

  assign rdata_next = rd_in ? read_word : READ_IDLE;
  assign irq_next   = any_pending;

  // Enable register
  always_ff @(posedge ref_clk_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      enable_reg <= ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // Read data and outputs
  always_ff @(posedge ref_clk_in or negedge nrst_sync) begin
    if (!nrst_sync) begin
      rdata_reg <= READ_IDLE;
      irq_reg   <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
      fault_reg <= fault_next;
    end
  end

  assign rdata_out                   = rdata_reg;
  assign irq_out                     = irq_reg;
  assign mode_fault_flag_out         = fault_reg;
  assign global_interrupt_enable_out = enable_reg;

  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking

  default disable iff (!nrst_sync);

  masked_no_irq_a : assert property (
    ((global_interrupt_flags_in & enable_reg) == 32'h00000000) |=> !irq_out
  ) else $error("masked source raised the interrupt");

  enabled_irq_a : assert property (
    ((global_interrupt_flags_in & enable_reg) != 32'h00000000) |=> irq_out
  ) else $error("enabled pending source gave no interrupt");

  flags_view_a : assert property (
    (rd_in && addr_in == FLAGS_VIEW_OFFSET) |=> (rdata_out == $past(global_interrupt_flags_in))
  ) else $error("flag view does not show raw flags");

  pending_view_a : assert property (
    (rd_in && addr_in == PENDING_OFFSET) |=>
      (rdata_out == ($past(global_interrupt_flags_in) & $past(enable_reg)))
  ) else $error("pending view is not flags and enables");

  reset_zero_a : assert property (
    @(posedge ref_clk_in) disable iff (1'b0)
    !nrst_sync |-> (enable_reg == ENABLE_RESET) && !irq_out && !mode_fault_flag_out
  ) else $error("enable word not cleared by reset");

  both_role_a : assert property (
    (wr_in && addr_in == ENABLE_OFFSET) |=>
      ((enable_reg & BOTH_ROLE_MASK) == ($past(wdata_in) & BOTH_ROLE_MASK))
  ) else $error("shared enable bit did not take the write");

  host_bits_a : assert property (
    (wr_in && addr_in == ENABLE_OFFSET && host_mode_in) |=>
      ((enable_reg & HOST_ONLY_MASK & field_mask) == ($past(wdata_in) & HOST_ONLY_MASK & field_mask))
  ) else $error("host enable bit did not take the write");

  device_bits_a : assert property (
    (wr_in && addr_in == ENABLE_OFFSET && !host_mode_in) |=>
      ((enable_reg & DEVICE_ONLY_MASK) == ($past(wdata_in) & DEVICE_ONLY_MASK))
  ) else $error("device enable bit did not take the write");

  role_guard_a : assert property (
    (wr_in && addr_in == ENABLE_OFFSET) |=>
      ((enable_reg & $past(role_bits)) == ($past(enable_reg) & $past(role_bits)))
  ) else $error("wrong role write changed an enable bit");

  fault_pulse_a : assert property (
    (wr_in && addr_in == ENABLE_OFFSET && role_touch) |=> mode_fault_flag_out
  ) else $error("mode fault not raised after a wrong role write");

  fault_cause_a : assert property (
    !(wr_in && addr_in == ENABLE_OFFSET) |=> !mode_fault_flag_out
  ) else $error("mode fault without an enable write");

  reserved_zero_a : assert property (
    (enable_reg & ~WRITABLE_MASK) == 32'h00000000
  ) else $error("reserved enable bit is set");

  hold_word_a : assert property (
    !(wr_in && addr_in == ENABLE_OFFSET) |=> $stable(enable_reg)
  ) else $error("enable word changed without a write");

  read_idle_a : assert property (
    !rd_in |=> (rdata_out == READ_IDLE)
  ) else $error("read data outside the read answer");

  early_suspend_a : assert property (
    (global_interrupt_flags_in == (32'h00000001 << EARLY_SUSPEND_BIT)) && !enable_reg[EARLY_SUSPEND_BIT]
      |=> !irq_out
  ) else $error("early suspend raised while disabled");

  write_then_irq_c : cover property (
    (wr_in && addr_in == ENABLE_OFFSET && wdata_in[WAKEUP_BIT]) ##1
      global_interrupt_flags_in[WAKEUP_BIT] ##1 irq_out
  );

  wrong_role_c : cover property (
    (wr_in && addr_in == ENABLE_OFFSET && role_touch) ##1 mode_fault_flag_out
  );

  masked_flag_c : cover property (
    global_interrupt_flags_in[BUS_RESET_BIT] && !enable_reg[BUS_RESET_BIT] ##1 !irq_out
  );

  shared_bit_c : cover property (
    host_mode_in && enable_reg[INCOMPLETE_BIT] ##[1:20] !host_mode_in && enable_reg[INCOMPLETE_BIT]
  );

  gated_single_c : cover property (
    (global_interrupt_flags_in == only_bit(EARLY_SUSPEND_BIT)) && early_suspend_irq_en ##1 irq_out
  );

  fault_exact_a : assert property (
    !(enable_hit && role_touch) |=> !mode_fault_flag_out
  ) else $error("mode fault without a wrong role change");

  pending_gate_a : assert property (
    pending == (global_interrupt_flags_in & enable_reg)
  ) else $error("gated pending word is wrong");

  enable_read_a : assert property (
    (rd_in && addr_in == ENABLE_OFFSET) |=> (rdata_out == $past(enable_reg))
  ) else $error("enable word read back wrong");

  unmapped_read_a : assert property (
    (rd_in && !enable_sel && !pending_sel && !flags_sel) |=> (rdata_out == READ_IDLE)
  ) else $error("unmapped read returned data");

  host_guard_a : assert property (
    (wr_in && addr_in == ENABLE_OFFSET && !host_mode_in) |=>
      ((enable_reg & HOST_ONLY_MASK) == ($past(enable_reg) & HOST_ONLY_MASK))
  ) else $error("host enable bit changed in device role");

  device_guard_a : assert property (
    (wr_in && addr_in == ENABLE_OFFSET && host_mode_in) |=>
      ((enable_reg & DEVICE_ONLY_MASK) == ($past(enable_reg) & DEVICE_ONLY_MASK))
  ) else $error("device enable bit changed in host role");

  wakeup_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(WAKEUP_BIT)) |=>
      (irq_out == $past(wakeup_irq_en))
  ) else $error("wakeup enable does not gate its source");

  session_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(SESSION_BIT)) |=>
      (irq_out == $past(session_irq_en))
  ) else $error("session enable does not gate its source");

  disconnect_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(DISCONNECT_BIT)) |=>
      (irq_out == $past(disconnect_irq_en))
  ) else $error("disconnect enable does not gate its source");

  id_pin_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(ID_PIN_BIT)) |=>
      (irq_out == $past(id_pin_change_irq_en))
  ) else $error("id pin enable does not gate its source");

  tx_empty_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(PERIODIC_TXFE_BIT)) |=>
      (irq_out == $past(periodic_tx_fifo_empty_irq_en))
  ) else $error("periodic fifo enable does not gate its source");

  channels_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(HOST_CHANNELS_BIT)) |=>
      (irq_out == $past(host_channels_irq_en))
  ) else $error("host channels enable does not gate its source");

  host_port_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(HOST_PORT_BIT)) |=>
      (irq_out == $past(host_port_irq_en))
  ) else $error("host port enable does not gate its source");

  periodic_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(INCOMPLETE_BIT)) && host_mode_in |=>
      (irq_out == $past(periodic_xfer_incomplete_irq_en))
  ) else $error("periodic incomplete enable does not gate its source");

  iso_out_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(INCOMPLETE_BIT)) && !host_mode_in |=>
      (irq_out == $past(iso_out_incomplete_irq_en))
  ) else $error("iso out incomplete enable does not gate its source");

  iso_in_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(ISO_IN_BIT)) |=>
      (irq_out == $past(iso_in_incomplete_irq_en))
  ) else $error("iso in incomplete enable does not gate its source");

  out_ep_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(OUT_EP_BIT)) |=>
      (irq_out == $past(out_endpoints_irq_en))
  ) else $error("out endpoints enable does not gate its source");

  in_ep_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(IN_EP_BIT)) |=>
      (irq_out == $past(in_endpoints_irq_en))
  ) else $error("in endpoints enable does not gate its source");

  end_frame_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(END_FRAME_BIT)) |=>
      (irq_out == $past(end_periodic_frame_irq_en))
  ) else $error("end of frame enable does not gate its source");

  iso_drop_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(ISO_DROP_BIT)) |=>
      (irq_out == $past(iso_out_drop_irq_en))
  ) else $error("iso drop enable does not gate its source");

  enum_done_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(ENUM_DONE_BIT)) |=>
      (irq_out == $past(enum_done_irq_en))
  ) else $error("enumeration enable does not gate its source");

  bus_reset_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(BUS_RESET_BIT)) |=>
      (irq_out == $past(bus_reset_irq_en))
  ) else $error("bus reset enable does not gate its source");

  suspend_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(SUSPEND_BIT)) |=>
      (irq_out == $past(suspend_irq_en))
  ) else $error("suspend enable does not gate its source");

  early_gate_a : assert property (
    (global_interrupt_flags_in == only_bit(EARLY_SUSPEND_BIT)) |=>
      (irq_out == $past(early_suspend_irq_en))
  ) else $error("early suspend enable does not gate its source");

endmodule

/* File: test/tb_top.sv */
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; \
  $display("BAD %s expected %h seen %h", nm, ex, gt); end end

module tb_top
  import irq_mask_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              ref_clk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = 12'h000;
  logic [DATA_W-1:0] wdata_in = 32'h0;
  logic              wr_in = 1'b0;
  logic              rd_in = 1'b0;
  logic [DATA_W-1:0] flags = 32'h0;
  logic              host_mode = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic [DATA_W-1:0] en_out;
  logic              fault_out;
  logic              irq_out;
  logic [DATA_W-1:0] en_model = 32'h0;
  logic [DATA_W-1:0] rd_exp[$];
  logic              fault_exp[$];
  logic              rd_q = 1'b0;
  logic              wr_q = 1'b0;
  int                err_total = 0;
  int                comparisons = 0;

  always #2 ref_clk_in = ~ref_clk_in;

  usb_irq_enable_mask uut (
    .ref_clk_in                  (ref_clk_in),
    .nrst_in                     (nrst_in),
    .addr_in                     (addr_in),
    .wdata_in                    (wdata_in),
    .wr_in                       (wr_in),
    .rd_in                       (rd_in),
    .rdata_out                   (rdata_out),
    .global_interrupt_flags_in   (flags),
    .host_mode_in                (host_mode),
    .global_interrupt_enable_out (en_out),
    .mode_fault_flag_out         (fault_out),
    .irq_out                     (irq_out)
  );

  // Marks the cycle in which an answer stands
  always @(posedge ref_clk_in) begin
    rd_q <= rd_in;
    wr_q <= wr_in && (addr_in == ENABLE_OFFSET);
  end

  // Output watcher takes the oldest note
  always @(negedge ref_clk_in) begin
    logic [DATA_W-1:0] ex_v;
    logic              fx_v;
    if (rd_q) begin
      ex_v = (rd_exp.size() != 0) ? rd_exp.pop_front() : 32'hDEADBEEF;
      `CHK("rdata", ex_v, rdata_out)
    end
    if (wr_q) begin
      fx_v = (fault_exp.size() != 0) ? fault_exp.pop_front() : 1'bx;
      `CHK("mode_fault", fx_v, fault_out)
    end
  end

  task automatic end_of_test();
    if (rd_exp.size() != 0 || fault_exp.size() != 0) begin
      err_total++;
      $display("BAD queue expected 0 seen %0d", rd_exp.size() + fault_exp.size());
    end
    $display("Counts: comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] wrong;
    logic [31:0] legal;
    @(posedge ref_clk_in);
    wrong = host_mode ? DEVICE_ONLY_MASK : HOST_ONLY_MASK;
    legal = WRITABLE_MASK & ~wrong;
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    if (a == ENABLE_OFFSET) begin
      fault_exp.push_back(((d ^ en_model) & wrong) != 32'h0);
      en_model = (en_model & ~legal) | (d & legal);
    end
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    rd_exp.push_back(e);
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
  endtask

  task automatic set_flags(input logic [31:0] f);
    @(posedge ref_clk_in);
    flags <= f;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    `CHK("irq", |(f & en_model), irq_out)
    `CHK("enable", en_model, en_out)
    rd(FLAGS_VIEW_OFFSET, f);
    rd(PENDING_OFFSET, f & en_model);
  endtask

  // Hang guard
  initial begin
    repeat (50000) @(posedge ref_clk_in);
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    void'($urandom(32'h590bf60f));
    repeat (12) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    rd(ENABLE_OFFSET, ENABLE_RESET);
    rd(12'h01C, READ_IDLE);
    set_flags(32'hFFFFFFFF);
    $display("Test reset values done");
    wr(ENABLE_OFFSET, WRITABLE_MASK);
    rd(ENABLE_OFFSET, en_model);
    host_mode <= 1'b1;
    wr(ENABLE_OFFSET, WRITABLE_MASK);
    rd(ENABLE_OFFSET, en_model);
    wr(ENABLE_OFFSET, 32'h0);
    rd(ENABLE_OFFSET, en_model);
    repeat (8) begin
      host_mode <= 1'($urandom % 2);
      wr(ENABLE_OFFSET, $urandom & WRITABLE_MASK);
      rd(ENABLE_OFFSET, en_model);
    end
    $display("Test role writes done");
    for (int r = 0; r < 2; r++) begin
      for (int b = 10; b < 32; b++) begin
        if (WRITABLE_MASK[b] && !(r == 0 ? HOST_ONLY_MASK[b] : DEVICE_ONLY_MASK[b])) begin
          host_mode <= r[0];
          wr(ENABLE_OFFSET, 32'h1 << b);
          set_flags(32'h1 << b);
          set_flags($urandom | (32'h1 << b));
          set_flags($urandom & ~(32'h1 << b));
        end
      end
    end
    $display("Test per source gating done");
    host_mode <= 1'b0;
    wr(ENABLE_OFFSET, 32'h0);
    host_mode <= 1'b1;
    wr(ENABLE_OFFSET, 32'h0);
    set_flags(32'hFFFFFFFF);
    $display("Test all masked done");
    wr(ENABLE_OFFSET, WRITABLE_MASK);
    @(posedge ref_clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    en_model = ENABLE_RESET;
    `CHK("enable", en_model, en_out)
    `CHK("irq", 1'b0, irq_out)
    @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    rd(ENABLE_OFFSET, ENABLE_RESET);
    repeat (2) @(posedge ref_clk_in);
    $display("Test second reset done");
    end_of_test();
  end

endmodule
